/* File: rtl/atmrx_cfg.svh */
`ifndef ATMRX_CFG_SVH
`define ATMRX_CFG_SVH
// ==========================================
// widths and defaults
`define ATMRX_BYTE_W 8
`define ATMRX_ADDR_W 5
`define ATMRX_HI_ADDR_W 3
`define ATMRX_LO_ADDR_W 2
`define ATMRX_CELL_LEN 53
`define ATMRX_CELL_MAX 64
`define ATMRX_MY_ADDR 5'h01
`define ATMRX_NULL_ADDR 5'h1f
`define ATMRX_SYNC_W 2
`endif

/* File: rtl/atmrx_pkg.sv */
package atmrx_pkg;
    // ==========================================
    // cell assembly states, gray along the path
    typedef enum logic [1:0]
    {
        ATMRX_HUNT = 2'b00,
        ATMRX_BODY = 2'b01
    } atmrx_state_t;
endpackage : atmrx_pkg

/* File: rtl/atmrx_skid.sv */
`timescale 1ns/100ps
`include "atmrx_cfg.svh"
module atmrx_skid #(
    parameter int WIDTH = `ATMRX_BYTE_W + 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // ==========================================
    // two-entry buffer: output register plus one parking entry
    if (WIDTH < 1)
    begin : g_bad_width
        $error("atmrx_skid: WIDTH must be positive");
    end
    logic hold_v, next_hold_v, skid_v, next_skid_v;
    logic [WIDTH-1:0] hold_d, next_hold_d, skid_d, next_skid_d;
    always_comb
    begin
        next_hold_v = hold_v;
        next_hold_d = hold_d;
        next_skid_v = skid_v;
        next_skid_d = skid_d;
        if (!hold_v || out_ready)
        begin
            if (skid_v)
            begin
                next_hold_v = 1'b1;
                next_hold_d = skid_d;
                next_skid_v = 1'b0;
            end
            else
            begin
                next_hold_v = in_valid;
                if (in_valid)
                begin
                    next_hold_d = in_data;
                end
            end
        end
        else if (in_valid && !skid_v)
        begin
            // stalled: park the word so the stall loses nothing
            next_skid_v = 1'b1;
            next_skid_d = in_data;
        end
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hold_v <= 1'b0;
            hold_d <= '0;
            skid_v <= 1'b0;
            skid_d <= '0;
        end
        else
        begin
            hold_v <= next_hold_v;
            hold_d <= next_hold_d;
            skid_v <= next_skid_v;
            skid_d <= next_skid_d;
        end
    end
    // outputs come straight from registers, no read mux
    assign in_ready = !skid_v;
    assign out_valid = hold_v;
    assign out_data = hold_d;
endmodule : atmrx_skid

/* File: rtl/atmrx_port.sv */
// Overview of operation
// - low enable asks capture of byte and start flag on a later clock.
// - byte flagged by start-of-cell begins a new cell.
// - respond only when the 5-bit slave select matches our address.
// - strap low ties off enable, start-of-cell and low select inputs.
// - upper select pins go to serial clocks unless strap is high.
// - space flag low means no room for a cell, high means room.
`timescale 1ns/100ps
`include "atmrx_cfg.svh"
module atmrx_port #(
    parameter int CELL_LEN = `ATMRX_CELL_LEN,
    parameter logic [`ATMRX_ADDR_W-1:0] MY_ADDR = `ATMRX_MY_ADDR
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // strap
    input wire logic CELL_PORT_STRAP,
    // link pins
    input wire logic RX_LINK_CLOCK,
    input wire logic RX_ENABLE_IN_N,
    input wire logic RX_START_OF_CELL,
    input wire logic [`ATMRX_BYTE_W-1:0] RX_CELL_BYTE_BUS,
    input wire logic [`ATMRX_LO_ADDR_W-1:0] RX_SLAVE_SELECT_LO,
    // shared upper select / serial clock pins
    input wire logic [`ATMRX_HI_ADDR_W-1:0] SHARED_PIN_IN,
    output logic [`ATMRX_HI_ADDR_W-1:0] SERIAL_ONE_CLOCKS,
    output logic RX_CELL_SPACE_FLAG,
    output logic RX_CELL_SPACE_FLAG_OE,
    // user side
    output logic BYTE_VALID,
    input wire logic BYTE_READY,
    output logic [`ATMRX_BYTE_W-1:0] BYTE_DATA,
    output logic BYTE_FIRST,
    output logic BYTE_LAST,
    output logic CELL_DROPPED
);
    // the null address must never match: it is the select that a strapped-off port sees
    if (CELL_LEN < 1 || CELL_LEN > `ATMRX_CELL_MAX || MY_ADDR == `ATMRX_NULL_ADDR)
    begin : g_bad_param
        $error("atmrx_port: bad CELL_LEN or MY_ADDR");
    end
    localparam int SW = `ATMRX_SYNC_W;
    localparam int PW = 3 + `ATMRX_BYTE_W + `ATMRX_ADDR_W;
    // ==========================================
    // strap capture; a boot pin, but still asynchronous, so two flops
    logic strap_meta, next_strap_meta, strap, next_strap;
    always_comb
    begin
        next_strap_meta = CELL_PORT_STRAP;
        next_strap = strap_meta;
    end
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            strap_meta <= 1'b0;
            strap <= 1'b0;
        end
        else
        begin
            strap_meta <= next_strap_meta;
            strap <= next_strap;
        end
    end
    // ==========================================
    // two-flop synchronisers; first stage read only by the second
    logic [PW-1:0] raw, sync_a, sync_b, next_a, next_b;
    always_comb
    begin
        raw = {RX_LINK_CLOCK, RX_ENABLE_IN_N, RX_START_OF_CELL, RX_CELL_BYTE_BUS,
               SHARED_PIN_IN, RX_SLAVE_SELECT_LO};
        next_a = raw;
        next_b = sync_a;
    end
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            sync_a <= {3'b010, {(PW-3){1'b0}}};
            sync_b <= {3'b010, {(PW-3){1'b0}}};
        end
        else
        begin
            sync_a <= next_a;
            sync_b <= next_b;
        end
    end
    logic lclk, en_n, soc;
    logic [`ATMRX_BYTE_W-1:0] dbyte;
    logic [`ATMRX_HI_ADDR_W-1:0] hi_pins;
    logic [`ATMRX_LO_ADDR_W-1:0] lo_pins;
    assign {lclk, en_n, soc, dbyte, hi_pins, lo_pins} = sync_b;
    // ==========================================
    // tie-off and pin routing
    logic en_eff, soc_eff, sel_hit;
    logic [`ATMRX_ADDR_W-1:0] sel;
    always_comb
    begin
        en_eff = strap && !en_n;
        soc_eff = strap && soc;
        sel = strap ? {hi_pins, lo_pins} : `ATMRX_NULL_ADDR;
        sel_hit = (sel == MY_ADDR);
    end
    // ==========================================
    // link clock edge detect and cell assembly
    logic lclk_d, next_lclk_d, rise;
    logic en_q, next_en_q;
    atmrx_pkg::atmrx_state_t state, next_state;
    logic [6:0] cnt, next_cnt;
    logic push, next_push, first, next_first, last, next_last, drop, next_drop;
    logic [`ATMRX_BYTE_W-1:0] pbyte, next_pbyte;
    logic fill_ready;
    logic [`ATMRX_HI_ADDR_W-1:0] ser, next_ser;
    logic space, next_space;
    always_comb
    begin
        next_lclk_d = lclk;
        rise = lclk && !lclk_d;
        next_en_q = rise ? (en_eff && sel_hit) : en_q;
        next_state = state;
        next_cnt = cnt;
        next_push = 1'b0;
        next_first = 1'b0;
        next_last = 1'b0;
        next_drop = 1'b0;
        next_pbyte = pbyte;
        // enable seen on the previous link edge; data taken on this one
        if (rise && en_q)
        begin
            unique case (state)
                atmrx_pkg::ATMRX_HUNT:
                begin
                    if (soc_eff)
                    begin
                        next_push = 1'b1;
                        next_first = 1'b1;
                        next_pbyte = dbyte;
                        next_cnt = 7'h1;
                        next_last = (CELL_LEN == 1);
                        next_state = (CELL_LEN == 1) ? atmrx_pkg::ATMRX_HUNT
                                                     : atmrx_pkg::ATMRX_BODY;
                    end
                end
                atmrx_pkg::ATMRX_BODY:
                begin
                    next_push = 1'b1;
                    next_pbyte = dbyte;
                    next_first = soc_eff;
                    if (soc_eff)
                    begin
                        next_drop = 1'b1;
                        next_cnt = 7'h1;
                    end
                    else
                    begin
                        next_cnt = cnt + 7'h1;
                        if (next_cnt == 7'(CELL_LEN))
                        begin
                            next_last = 1'b1;
                            next_state = atmrx_pkg::ATMRX_HUNT;
                        end
                    end
                end
            endcase
        end
        // buffer full loses the byte; the space flag should prevent this
        if (next_push && !fill_ready)
        begin
            next_push = 1'b0;
            next_drop = 1'b1;
        end
        next_ser = strap ? '0 : hi_pins;
        // room only while the strap is high and the buffer is empty; cell state is not looked at
        next_space = strap && fill_ready && !BYTE_VALID;
    end
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            lclk_d <= 1'b0;
            en_q <= 1'b0;
            state <= atmrx_pkg::ATMRX_HUNT;
            cnt <= 7'h0;
            push <= 1'b0;
            first <= 1'b0;
            last <= 1'b0;
            drop <= 1'b0;
            pbyte <= '0;
            ser <= '0;
            space <= 1'b0;
        end
        else
        begin
            lclk_d <= next_lclk_d;
            en_q <= next_en_q;
            state <= next_state;
            cnt <= next_cnt;
            push <= next_push;
            first <= next_first;
            last <= next_last;
            drop <= next_drop;
            pbyte <= next_pbyte;
            ser <= next_ser;
            space <= next_space;
        end
    end
    // ==========================================
    // output buffer
    logic [`ATMRX_BYTE_W+1:0] out_word;
    logic out_v;
    atmrx_skid #(.WIDTH(`ATMRX_BYTE_W + 2)) u_buf (
        .clk(CLK),
        .rst(RST),
        .in_valid(push),
        .in_ready(fill_ready),
        .in_data({first, last, pbyte}),
        .out_valid(out_v),
        .out_ready(BYTE_READY),
        .out_data(out_word)
    );
    // buffer outputs are its own registers, so valid and data stay aligned
    assign BYTE_VALID = out_v;
    assign BYTE_FIRST = out_word[`ATMRX_BYTE_W+1];
    assign BYTE_LAST = out_word[`ATMRX_BYTE_W];
    assign BYTE_DATA = out_word[`ATMRX_BYTE_W-1:0];
    assign SERIAL_ONE_CLOCKS = ser;
    assign RX_CELL_SPACE_FLAG = space;
    assign RX_CELL_SPACE_FLAG_OE = strap;
    assign CELL_DROPPED = drop;
endmodule : atmrx_port

/* File: test/atmrx_monitor.sv */
`timescale 1ns/100ps
`include "atmrx_cfg.svh"
module atmrx_monitor (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // strap and shared pins
    input wire logic CELL_PORT_STRAP,
    input wire logic [`ATMRX_HI_ADDR_W-1:0] SHARED_PIN_IN,
    input wire logic [`ATMRX_HI_ADDR_W-1:0] SERIAL_ONE_CLOCKS,
    input wire logic RX_CELL_SPACE_FLAG,
    input wire logic RX_CELL_SPACE_FLAG_OE,
    // user side
    input wire logic BYTE_VALID,
    input wire logic BYTE_READY,
    input wire logic [`ATMRX_BYTE_W-1:0] BYTE_DATA,
    input wire logic BYTE_FIRST,
    input wire logic CELL_DROPPED
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // ==========================================
    // strap: two sync flops, plus an output register on space flag and serial clocks, so history reaches past them
    a_oe_tracks_strap: assert property (
        (!RST && $stable(CELL_PORT_STRAP)) [*3] |-> RX_CELL_SPACE_FLAG_OE == CELL_PORT_STRAP)
        else $error("space flag enable off strap");
    a_space_off_strap: assert property (
        !CELL_PORT_STRAP [*4] |-> !RX_CELL_SPACE_FLAG) else $error("space flag with strap low");
    a_no_bytes_off: assert property (
        !CELL_PORT_STRAP [*8] |-> !BYTE_VALID) else $error("byte with strap low");
    a_serial_gets_pins: assert property (
        (!CELL_PORT_STRAP && $stable(SHARED_PIN_IN)) [*4] |-> SERIAL_ONE_CLOCKS == SHARED_PIN_IN)
        else $error("serial clocks not passed");
    a_serial_quiet: assert property (
        CELL_PORT_STRAP [*4] |-> SERIAL_ONE_CLOCKS == 3'h0) else $error("serial clocks leak");
    // ==========================================
    // user side and space
    a_valid_holds: assert property (
        BYTE_VALID && !BYTE_READY |=> BYTE_VALID && $stable(BYTE_DATA) && $stable(BYTE_FIRST))
        else $error("byte changed while stalled");
    a_space_pending: assert property (
        BYTE_VALID && $past(BYTE_VALID) |-> !RX_CELL_SPACE_FLAG)
        else $error("space flag with byte pending");
    a_drop_pulse: assert property (
        CELL_DROPPED |=> !CELL_DROPPED) else $error("drop not a pulse");
endmodule : atmrx_monitor

bind atmrx_port atmrx_monitor atmrx_monitor_i (.CLK, .RST, .CELL_PORT_STRAP, .SHARED_PIN_IN,
    .SERIAL_ONE_CLOCKS, .RX_CELL_SPACE_FLAG, .RX_CELL_SPACE_FLAG_OE, .BYTE_VALID,
    .BYTE_READY, .BYTE_DATA, .BYTE_FIRST, .CELL_DROPPED);

/* File: test/atmrx_master.sv */
`timescale 1ns/100ps
module atmrx_master (
    // link pins
    output logic lclk,
    output logic enb_n,
    output logic soc,
    output logic [7:0] bus,
    output logic [4:0] sel
);
    initial
    begin
        lclk = 1'b0;
        enb_n = 1'b1;
        soc = 1'b0;
        bus = 8'h00;
        sel = 5'h1f;
    end
    // first edge only primes: enable seen there qualifies the next edge
    task automatic send(input logic [4:0] a, input int n, input logic [7:0] b, input logic s);
        sel = a;
        enb_n = 1'b0;
        #40 lclk = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            #40 lclk = 1'b0;
            bus = b + 8'(i);
            soc = s && i == 0;
            enb_n = i == n - 1;
            #40 lclk = 1'b1;
        end
        // hold past the last edge; then pulled-up select, garbage on the bus
        #40 lclk = 1'b0;
        sel = 5'h1f;
        soc = 1'b0;
        bus = ~bus;
    endtask : send
endmodule : atmrx_master

/* File: test/testbench.sv */
`timescale 1ns/100ps
module testbench;
    localparam int CELL = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic strap = 1'b1;
    logic ready_en = 1'b1;
    logic [2:0] ser = 3'h0;
    logic lclk, enb_n, soc, valid, first, last, drop, space, space_oe;
    logic [7:0] bus, data;
    logic [4:0] sel;
    logic [2:0] ser_out;
    logic [9:0] got[$];
    int n_errors = 0;
    int checked = 0;
    int n_drop = 0;
    always #5 clk = ~clk;
    atmrx_master atmrx_master_i (.lclk(lclk), .enb_n(enb_n), .soc(soc), .bus(bus), .sel(sel));
    atmrx_port #(.CELL_LEN(CELL)) atmrx_port_i (.CLK(clk), .RST(rst), .CELL_PORT_STRAP(strap),
        .RX_LINK_CLOCK(lclk), .RX_ENABLE_IN_N(enb_n), .RX_START_OF_CELL(soc),
        .RX_CELL_BYTE_BUS(bus), .RX_SLAVE_SELECT_LO(sel[1:0]),
        .SHARED_PIN_IN(strap ? sel[4:2] : ser), .SERIAL_ONE_CLOCKS(ser_out),
        .RX_CELL_SPACE_FLAG(space), .RX_CELL_SPACE_FLAG_OE(space_oe), .BYTE_VALID(valid),
        .BYTE_READY(valid & ready_en), .BYTE_DATA(data), .BYTE_FIRST(first),
        .BYTE_LAST(last), .CELL_DROPPED(drop));
    always @(posedge clk)
    begin
        if (valid === 1'b1 && ready_en === 1'b1)
            got.push_back({first, last, data});
        if (drop === 1'b1)
            n_drop++;
    end
    task automatic give_verdict();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] seen);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // bounded wait for n bytes, then a quiet spell to catch extras
    task automatic take(input int n);
        for (int k = 0; k < 200 && got.size() < n; k++)
            @(posedge clk);
        tick(20);
        check("bytes", 10'(n), 10'(got.size()));
        if (got.size() < n)
            give_verdict();
    endtask : take
    task automatic t_basic();
        atmrx_master_i.send(5'h01, 2, 8'h10, 1'b0);
        take(0);
        atmrx_master_i.send(5'h01, CELL, 8'h20, 1'b1);
        take(CELL);
        for (int i = 0; i < CELL; i++)
            check("byte", {i == 0, i == CELL - 1, 8'h20 + 8'(i)}, got[i]);
        check("space", 10'h1, {9'h0, space});
        got.delete();
    endtask : t_basic
    // a start mid-cell restarts the cell and pulses the drop flag once
    task automatic t_restart();
        int n0;
        n0 = n_drop;
        atmrx_master_i.send(5'h01, 2, 8'ha0, 1'b1);
        atmrx_master_i.send(5'h01, CELL, 8'hb0, 1'b1);
        take(CELL + 2);
        check("byte", {2'b10, 8'ha0}, got[0]);
        check("byte", {2'b00, 8'ha1}, got[1]);
        for (int i = 0; i < CELL; i++)
            check("byte", {i == 0, i == CELL - 1, 8'hb0 + 8'(i)}, got[i + 2]);
        check("dropped", 10'h1, 10'(n_drop - n0));
        got.delete();
    endtask : t_restart
    task automatic t_other();
        for (int a = 0; a < 32; a += 6)
        begin
            atmrx_master_i.send(5'(a), CELL, 8'h40, 1'b1);
            take(0);
        end
    endtask : t_other
    task automatic t_stall();
        ready_en = 1'b0;
        atmrx_master_i.send(5'h01, CELL, 8'h60, 1'b1);
        tick(10);
        check("space", 10'h0, {9'h0, space});
        check("dropped", 10'h1, {9'h0, n_drop > 0});
        ready_en = 1'b1;
        take(2);
        check("byte", {2'b10, 8'h60}, got[0]);
        check("byte", {2'b00, 8'h61}, got[1]);
        got.delete();
    endtask : t_stall
    task automatic t_strap();
        strap = 1'b0;
        ser = 3'h5;
        tick(5);
        check("serial", 10'h5, {7'h0, ser_out});
        check("oe", 10'h0, {9'h0, space_oe});
        atmrx_master_i.send(5'h01, CELL, 8'h80, 1'b1);
        take(0);
        strap = 1'b1;
        tick(5);
        check("serial", 10'h0, {7'h0, ser_out});
        check("oe", 10'h1, {9'h0, space_oe});
    endtask : t_strap
    initial
    begin
        tick(5);
        rst = 1'b0;
        tick(4);
        t_basic();
        t_restart();
        t_other();
        t_stall();
        t_strap();
        t_basic();
        give_verdict();
    end
endmodule : testbench
